// ==== rtl/dts_regs.svh ====
/*
 * Register offsets, field positions, reset values and counts of the
 * debug trigger and status block.
 * Assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.
 */
`ifndef DTS_REGS_SVH
`define DTS_REGS_SVH
// ****************
// Offsets
// ****************
`define DTS_OFF_CTRL 32'h0000_0000
`define DTS_OFF_TRIG 32'h0000_0004
`define DTS_OFF_STAT 32'h0000_0008
// ****************
// Field positions
// ****************
`define DTS_CTRL_EN 7
`define DTS_CTRL_ARM 6
`define DTS_TRG_SEL 7
`define DTS_TRG_BEGIN 6
// ****************
// Values and counts
// ****************
`define DTS_RST_BYTE 8'h00
`define DTS_FIFO_WORDS 4'h8
`define DTS_FIFO_LAST 4'h7
`define DTS_RESP_OKAY 2'h0
`define DTS_RESP_SLVERR 2'h2
`define DTS_M_AONLY 4'h0
`define DTS_M_AORB 4'h1
`define DTS_M_ATHENB 4'h2
`define DTS_M_EVB 4'h3
`define DTS_M_AEVB 4'h4
`define DTS_M_AANDB 4'h5
`define DTS_M_ANOTB 4'h6
`define DTS_M_INRNG 4'h7
`define DTS_M_OUTRNG 4'h8
`endif

// ==== rtl/dts_pkg.sv ====
/*
 * Types shared by the debug trigger and status block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dts_pkg;
	// ****************
	// Bus slave state
	// ****************
	typedef struct packed {
		logic aw_free;
		logic [31:0] awaddr;
		logic w_free;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_free;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} dts_axi_t;
	// ****************
	// Block state
	// ****************
	typedef struct packed {
		logic en;
		logic arm;
		logic [5:0] ctrl_lo;
		logic tsel;
		logic tbeg;
		logic [3:0] mode;
		logic flag_a;
		logic flag_b;
		logic [3:0] cnt;
		logic a_seen;
		logic storing;
		logic store_pulse;
		logic store_byte;
		logic trig_out;
		logic restart;
	} dts_state_t;
endpackage : dts_pkg

// ==== rtl/dts_axil.sv ====
/*
 * AXI4-Lite slave front end: takes one write and one read at a time.
 * Assumes the owner decodes addresses and supplies read data at once.
 */
`include "dts_regs.svh"
module dts_axil
	import dts_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic rready,
	output logic rvalid,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Owner side
	output logic wr_en,
	output logic [31:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_map,
	input wire logic [31:0] rd_data,
	input wire logic rd_map
);
	dts_axi_t s;
	dts_axi_t next_s;

	// Address and data stay held until the response is taken
	assign wr_en = !s.aw_free && !s.w_free && !s.bvalid;
	assign wr_addr = s.awaddr;
	assign wr_data = s.wdata;
	assign wr_strb = s.wstrb;
	assign awready = s.aw_free;
	assign wready = s.w_free;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.ar_free;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;

	always_comb begin
		next_s = s;
		if (awvalid && s.aw_free) begin
			next_s.aw_free = 1'b0;
			next_s.awaddr = awaddr;
		end
		if (wvalid && s.w_free) begin
			next_s.w_free = 1'b0;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end
		if (wr_en) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = wr_map ? `DTS_RESP_OKAY : `DTS_RESP_SLVERR;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
			next_s.aw_free = 1'b1;
			next_s.w_free = 1'b1;
		end
		if (arvalid && s.ar_free) begin
			next_s.ar_free = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_data;
			next_s.rresp = rd_map ? `DTS_RESP_OKAY : `DTS_RESP_SLVERR;
		end
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
			next_s.ar_free = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.aw_free <= 1'b1;
			s.w_free <= 1'b1;
			s.ar_free <= 1'b1;
		end else begin
			s <= next_s;
		end
	end
endmodule : dts_axil

// ==== rtl/dts_trig.sv ====
/*
 * Trigger mode decoder: combines qualified comparator events per mode.
 * Assumes events are already qualified by access or by execution.
 */
`include "dts_regs.svh"
module dts_trig (
	// Mode
	input wire logic [3:0] mode,
	// Events
	input wire logic a_ev,
	input wire logic b_ev,
	input wire logic qual,
	input wire logic in_rng,
	input wire logic a_seen,
	// Decisions
	output logic trig,
	output logic evonly,
	output logic a_arm
);
	always_comb begin
		trig = 1'b0;
		a_arm = 1'b0;
		case (mode)
			`DTS_M_AONLY: trig = a_ev;
			`DTS_M_AORB: trig = a_ev || b_ev;
			`DTS_M_ATHENB: begin
				trig = a_seen && b_ev;
				a_arm = a_ev;
			end
			`DTS_M_EVB: trig = b_ev;
			`DTS_M_AEVB: begin
				trig = a_seen && b_ev;
				a_arm = a_ev;
			end
			`DTS_M_AANDB: trig = a_ev && b_ev;
			`DTS_M_ANOTB: trig = a_ev && !b_ev;
			`DTS_M_INRNG: trig = qual && in_rng;
			`DTS_M_OUTRNG: trig = qual && !in_rng;
			default: trig = 1'b0;
		endcase
	end

	assign evonly = (mode == `DTS_M_EVB) || (mode == `DTS_M_AEVB);
endmodule : dts_trig

// ==== rtl/dts_top.sv ====
/*
 * Debug trigger selection and run status, registers on AXI4-Lite.
 * Assumes comparator results and strobes on aclk; FIFO datapath outside.
 */
// Notes on behaviour
// - Trigger setup readable always, writable only while unarmed; bits 4,5 read zero.
// - Execute-qualify set: only executed opcodes trigger, at match address or, in modes 7 and 8, by range.
// - Trace-start bit picks circular-until-trigger or trigger-starts-storage.
// - Event-only modes ignore trace-start bit and always run as begin trace.
// - Mode codes 0 to 6 decode the comparator combination modes.
// - Mode 7 triggers inside range A..B, mode 8 outside it.
// - Mode codes 9 to 15 never trigger.
// - Status register is read-only; writes change nothing.
// - A-hit flag clears at run start, sets on a comparator A match.
// - B-hit flag clears at run start, sets on a comparator B match.
// - Run-active flag mirrors the run control while enabled.
// - Run ends on full FIFO in begin trace, on trigger in end trace.
// - Writing zero to run control or enable stops the run.
// - Valid word count clears at start, counts stored words up to eight.
// - Reading the FIFO never decrements the valid word count.
// - Writing run control and enable both to one sets it; run completion clears it.
// - Module enable cannot be set while the chip is secured.
// - Event-only modes store only eight-bit data per FIFO word.
`include "dts_regs.svh"
module dts_top
	import dts_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Chip state
	input wire logic secure,
	// Bus comparators and opcode tracker
	input wire logic access_strobe,
	input wire logic exec_strobe,
	input wire logic cmp_a_match,
	input wire logic cmp_b_match,
	input wire logic addr_ge_a,
	input wire logic addr_le_b,
	// FIFO datapath control
	output logic fifo_restart,
	output logic store_strobe,
	output logic store_byte_only,
	output logic trigger_event,
	output logic run_active
);
	dts_state_t s;
	dts_state_t next_s;
	logic wr_en;
	logic [31:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_map;
	logic [31:0] rd_data;
	logic rd_map;
	logic qual;
	logic a_ev;
	logic b_ev;
	logic in_rng;
	logic trig;
	logic evonly;
	logic a_arm;
	logic beg_eff;
	logic store_now;

	// ****************
	// Bus slave
	// ****************
	dts_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.rready(rready),
		.rvalid(rvalid),
		.rdata(rdata),
		.rresp(rresp),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_map(wr_map),
		.rd_data(rd_data),
		.rd_map(rd_map)
	);

	assign wr_map = (wr_addr == `DTS_OFF_CTRL) || (wr_addr == `DTS_OFF_TRIG)
		|| (wr_addr == `DTS_OFF_STAT);

	// ****************
	// Read decode
	// ****************
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_map = 1'b1;
		case (araddr)
			`DTS_OFF_CTRL: rd_data = {24'h00_0000, s.en, s.arm, s.ctrl_lo};
			`DTS_OFF_TRIG: rd_data = {24'h00_0000, s.tsel, s.tbeg, 2'h0, s.mode};
			`DTS_OFF_STAT: rd_data = {24'h00_0000, s.flag_a, s.flag_b, s.arm, 1'b0, s.cnt};
			default: rd_map = 1'b0;
		endcase
	end

	// ****************
	// Trigger qualification
	// ****************
	// Tag style waits for the tracker to confirm execution
	assign qual = s.tsel ? exec_strobe : access_strobe;
	assign a_ev = qual && cmp_a_match;
	assign b_ev = qual && cmp_b_match;
	assign in_rng = addr_ge_a && addr_le_b;

	dts_trig u_trig (
		.mode(s.mode),
		.a_ev(a_ev),
		.b_ev(b_ev),
		.qual(qual),
		.in_rng(in_rng),
		.a_seen(s.a_seen),
		.trig(trig),
		.evonly(evonly),
		.a_arm(a_arm)
	);

	assign beg_eff = s.tbeg || evonly;

	// Event-only stores just the B events; begin trace after trigger
	always_comb begin
		if (evonly) begin
			store_now = trig;
		end else if (beg_eff) begin
			store_now = qual && (s.storing || trig);
		end else begin
			store_now = qual;
		end
	end

	// ****************
	// Next state
	// ****************
	always_comb begin
		next_s = s;
		next_s.store_pulse = 1'b0;
		next_s.trig_out = 1'b0;
		next_s.restart = 1'b0;
		if (s.arm) begin
			if (a_ev) begin
				next_s.flag_a = 1'b1;
			end
			if (b_ev) begin
				next_s.flag_b = 1'b1;
			end
			if (a_arm) begin
				next_s.a_seen = 1'b1;
			end
			next_s.trig_out = trig;
			if (store_now) begin
				next_s.store_pulse = 1'b1;
				next_s.store_byte = evonly;
				// Saturates: a circular end trace keeps at most eight
				if (s.cnt != `DTS_FIFO_WORDS) begin
					next_s.cnt = s.cnt + 4'h1;
				end
			end
			if (beg_eff && trig) begin
				next_s.storing = 1'b1;
			end
			if (beg_eff && store_now && (s.cnt == `DTS_FIFO_LAST)) begin
				next_s.arm = 1'b0;
			end
			if (!beg_eff && trig) begin
				next_s.arm = 1'b0;
			end
		end
		if (wr_en && wr_strb[0]) begin
			case (wr_addr)
				`DTS_OFF_CTRL: begin
					next_s.en = wr_data[`DTS_CTRL_EN] && !secure;
					next_s.ctrl_lo = wr_data[5:0];
					if (wr_data[`DTS_CTRL_ARM] && next_s.en) begin
						if (!s.arm) begin
							next_s.arm = 1'b1;
							next_s.flag_a = 1'b0;
							next_s.flag_b = 1'b0;
							next_s.cnt = 4'h0;
							next_s.a_seen = 1'b0;
							next_s.storing = 1'b0;
							next_s.restart = 1'b1;
						end
					end else begin
						next_s.arm = 1'b0;
					end
				end
				`DTS_OFF_TRIG: begin
					if (!s.arm) begin
						next_s.tsel = wr_data[`DTS_TRG_SEL];
						next_s.tbeg = wr_data[`DTS_TRG_BEGIN];
						next_s.mode = wr_data[3:0];
					end
				end
				default: begin
					// Status is read-only: nothing to do
					next_s.restart = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ****************
	// Outputs
	// ****************
	// Count is only touched by stores and starts, never by readout
	assign fifo_restart = s.restart;
	assign store_strobe = s.store_pulse;
	assign store_byte_only = s.store_byte;
	assign trigger_event = s.trig_out;
	assign run_active = s.arm;

	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_cfg_locked: assert property (s.arm && wr_en && wr_strb[0]
		&& (wr_addr == `DTS_OFF_TRIG) |=> $stable(s.mode) && $stable(s.tsel))
		else $error("trigger setup changed while armed");
	a_cfg_zero: assert property ((arvalid && arready && (araddr == `DTS_OFF_TRIG))
		|=> rdata[5:4] == 2'h0)
		else $error("trigger setup bits 5:4 not zero");
	a_tag_qual: assert property (s.tsel && !exec_strobe |-> !trig)
		else $error("tag trigger without execution");
	a_no_trig: assert property ((s.mode > `DTS_M_OUTRNG) |-> !trig)
		else $error("reserved mode produced a trigger");
	a_end_stop: assert property (s.arm && !beg_eff && trig && !wr_en
		|=> !s.arm && !run_active)
		else $error("end trace did not stop on trigger");
	a_full_stop: assert property (s.arm && beg_eff && store_now
		&& (s.cnt == `DTS_FIFO_LAST) && !wr_en |=> !s.arm && (s.cnt == `DTS_FIFO_WORDS))
		else $error("begin trace did not stop when full");
	a_status_ro: assert property (!s.arm && wr_en && (wr_addr == `DTS_OFF_STAT)
		|=> $stable(s.cnt) && $stable(s.flag_a) && $stable(s.flag_b))
		else $error("status changed by a write");
	a_start_clear: assert property (!s.arm ##1 s.arm |-> (s.cnt == 4'h0)
		&& !s.flag_a && !s.flag_b && fifo_restart)
		else $error("run start did not clear status");
	a_secure_en: assert property (secure && !s.en |=> !s.en)
		else $error("enable set while secured");
	a_hold_idle: assert property (!s.arm && !wr_en |=> $stable(s.cnt)
		&& $stable(s.flag_a) && $stable(s.flag_b))
		else $error("status moved while not armed");
	a_cnt_max: assert property (s.cnt <= `DTS_FIFO_WORDS)
		else $error("valid count above eight");
	a_byte_only: assert property (store_strobe |-> store_byte_only == $past(evonly))
		else $error("store width does not follow mode");
	a_stop_wr: assert property (wr_en && wr_strb[0] && (wr_addr == `DTS_OFF_CTRL)
		&& !wr_data[`DTS_CTRL_ARM] |=> !run_active)
		else $error("run not stopped by software");
	a_end_store: assert property (s.arm && !beg_eff && qual |=> store_strobe)
		else $error("end trace skipped a store");
	a_evonly_run: assert property (s.arm && evonly && trig && !wr_en
		&& (s.cnt != `DTS_FIFO_LAST) |=> run_active)
		else $error("event-only trigger ended the run");
endmodule : dts_top

// ==== tb/dts_cmp_model.sv ====
/*
 * Model of the bus comparators and opcode tracker that feed the trigger block.
 * Assumes the bench calls hit once for each qualifying cycle it wants.
 */
module dts_cmp_model (
	// Clock
	input wire logic aclk,
	// Comparator side
	output logic access_strobe,
	output logic exec_strobe,
	output logic cmp_a_match,
	output logic cmp_b_match,
	output logic addr_ge_a,
	output logic addr_le_b
);
	initial begin
		{access_strobe, exec_strobe, cmp_a_match, cmp_b_match, addr_ge_a, addr_le_b} = 6'h00;
	end
	// Levels mean nothing outside a strobe, so they flip afterwards
	task automatic hit(input logic acc, ex, a, b, ge, le);
		@(posedge aclk);
		access_strobe <= acc;
		exec_strobe <= ex;
		cmp_a_match <= a;
		cmp_b_match <= b;
		addr_ge_a <= ge;
		addr_le_b <= le;
		@(posedge aclk);
		access_strobe <= 1'b0;
		exec_strobe <= 1'b0;
		cmp_a_match <= !a;
		cmp_b_match <= !b;
		addr_ge_a <= !ge;
		addr_le_b <= !le;
	endtask : hit
endmodule : dts_cmp_model

// ==== tb/debug_trigger_and_status_bench.sv ====
/*
 * Self-checking bench of the debug trigger and status block.
 * Assumes dts_top, its register header and the comparator model.
 */
`include "dts_regs.svh"
module debug_trigger_and_status_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0, secure = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic acc_s, exe_s, ma, mb, ge, le;
	logic restart, store, byte_only, trig, active;
	logic [1:0] rs;
	logic [31:0] rd;
	int n_errors = 0, comparisons = 0, tally, restarts = 0;
	always #25 aclk = ~aclk;
	// Restart is a one-cycle pulse that no bus task can see, so it is counted
	always @(posedge aclk) begin
		if (restart === 1'b1) restarts++;
	end
	// Bus answers are always taken at once
	dts_top dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hF), .bvalid(bvalid), .bready(1'b1), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(1'b1),
		.rdata(rdata), .rresp(rresp), .secure(secure), .access_strobe(acc_s),
		.exec_strobe(exe_s), .cmp_a_match(ma), .cmp_b_match(mb), .addr_ge_a(ge),
		.addr_le_b(le), .fifo_restart(restart), .store_strobe(store),
		.store_byte_only(byte_only), .trigger_event(trig), .run_active(active));
	dts_cmp_model model_u (.aclk(aclk), .access_strobe(acc_s), .exec_strobe(exe_s),
		.cmp_a_match(ma), .cmp_b_match(mb), .addr_ge_a(ge), .addr_le_b(le));
	// ****************
	// Shared tasks
	// ****************
	task automatic chk(input string nm, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			n_errors++;
		end
	endtask : chk
	task automatic axw(input logic [31:0] ad, dt);
		logic ta, tw, tb;
		int n;
		n = 0;
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			rs = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
		end while (!tb && n < 40);
		if (!tb) n_errors++;
		#1;
	endtask : axw
	task automatic axr(input logic [31:0] ad);
		logic ta, tv;
		int n;
		n = 0;
		araddr <= ad;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tv = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			n++;
		end while (!tv && n < 40);
		if (!tv) n_errors++;
		#1;
	endtask : axr
	task automatic setup(input logic [7:0] t);
		axw(`DTS_OFF_CTRL, 32'h00);
		chk("run_active", 1'b0, active);
		axw(`DTS_OFF_TRIG, {24'h0, t});
		axw(`DTS_OFF_CTRL, 32'hC0);
		chk("run_active", 1'b1, active);
	endtask : setup
	task automatic hit(input logic acc, ex, a, b, g, l);
		model_u.hit(acc, ex, a, b, g, l);
		#1;
		if (store === 1'b1) tally++;
	endtask : hit
	// ****************
	// Scenarios
	// ****************
	task automatic regs_and_refusals();
		axr(`DTS_OFF_STAT);
		chk("status after reset", 32'h0, rd);
		axr(32'h0000_000C);
		chk("unmapped rresp", `DTS_RESP_SLVERR, rs);
		axw(32'h0000_000C, 32'hFF);
		chk("unmapped bresp", `DTS_RESP_SLVERR, rs);
		axw(`DTS_OFF_TRIG, 32'hFF);
		axr(`DTS_OFF_TRIG);
		chk("trigger setup", 32'hCF, rd);
		setup(8'h41);
		axw(`DTS_OFF_TRIG, 32'h00);
		axr(`DTS_OFF_TRIG);
		chk("trigger setup armed", 32'h41, rd);
		axw(`DTS_OFF_STAT, 32'hFF);
		axr(`DTS_OFF_STAT);
		chk("status", 32'h20, rd);
		axw(`DTS_OFF_CTRL, 32'h00);
		secure <= 1'b1;
		axw(`DTS_OFF_CTRL, 32'hC0);
		axr(`DTS_OFF_CTRL);
		chk("enable when secured", 1'b0, rd[7]);
		chk("run_active secured", 1'b0, active);
		secure <= 1'b0;
	endtask : regs_and_refusals
	task automatic begin_trace_count();
		int r0;
		setup(8'h41);
		tally = 0;
		hit(1, 0, 0, 1, 0, 0);
		chk("trigger_event", 1'b1, trig);
		chk("store_strobe", 1'b1, store);
		for (int i = 1; i < 8; i++) begin
			hit(1, 0, 0, 0, 0, 0);
			chk("run_active", i < 7, active);
		end
		axr(`DTS_OFF_STAT);
		chk("status full", 32'h48, rd);
		chk("word tally", `DTS_FIFO_WORDS, tally[3:0]);
		axw(`DTS_OFF_STAT, 32'h00);
		axr(`DTS_OFF_STAT);
		chk("status after write", 32'h48, rd);
		r0 = restarts;
		setup(8'h41);
		chk("fifo_restart pulses", r0 + 1, restarts);
		axr(`DTS_OFF_STAT);
		chk("status new run", 32'h20, rd);
	endtask : begin_trace_count
	task automatic end_trace_and_qualify();
		setup(8'h00);
		hit(1, 0, 0, 0, 0, 0);
		chk("store_strobe end trace", 1'b1, store);
		hit(1, 0, 1, 0, 0, 0);
		chk("trigger_event", 1'b1, trig);
		chk("run_active end trace", 1'b0, active);
		axr(`DTS_OFF_STAT);
		chk("status flags", 32'h80, rd & 32'hF0);
		setup(8'hC1);
		hit(1, 0, 1, 0, 0, 0);
		chk("trigger_event no exec", 1'b0, trig);
		hit(0, 1, 1, 0, 0, 0);
		chk("trigger_event exec", 1'b1, trig);
		setup(8'h03);
		hit(1, 0, 0, 1, 0, 0);
		chk("store_byte_only", 1'b1, byte_only);
		chk("run_active event only", 1'b1, active);
	endtask : end_trace_and_qualify
	task automatic mode_table();
		// Mode, a, b, ge, le, expected trigger
		logic [8:0] tbl [13] = '{9'h011, 9'h029, 9'h058, 9'h069, 9'h090, 9'h0B9,
			9'h0A8, 9'h0D1, 9'h0D8, 9'h0E7, 9'h0E2, 9'h105, 9'h106};
		for (int i = 0; i < 13; i++) begin
			setup({4'h4, tbl[i][8:5]});
			hit(1, 0, tbl[i][4], tbl[i][3], tbl[i][2], tbl[i][1]);
			chk("trigger_event mode", tbl[i][0], trig);
		end
		setup(8'h42);
		hit(1, 0, 1, 0, 0, 0);
		hit(1, 0, 0, 1, 0, 0);
		chk("trigger_event a then b", 1'b1, trig);
		for (int m = 9; m < 16; m++) begin
			setup({4'h4, 4'(m)});
			hit(1, 0, 1, 1, 1, 1);
			chk("trigger_event idle mode", 1'b0, trig);
		end
	endtask : mode_table
	task automatic complete_run();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		regs_and_refusals();
		begin_trace_count();
		end_trace_and_qualify();
		mode_table();
		complete_run();
	end
	// Whole run needs a few hundred cycles
	initial begin
		#1_000_000;
		n_errors++;
		complete_run();
	end
endmodule : debug_trigger_and_status_bench
